// >>> display_ram_addressing.sv
// Display RAM addressing: host command engine, pointer stepping, line
// counter and segment latch. Assumes line latch pulse and frame marker
// come from timing logic on the same clock; host commands arrive in order.
`default_nettype none

module display_ram_addressing
  import display_ram_pkg::*;
#(
  parameter int CMD_DEPTH = display_ram_pkg::FIFO_DEPTH
) (
  input  wire logic                                            clk,
  input  wire logic                                            rst,
  input  wire logic                                            cmd_valid,
  output var  logic                                            cmd_ready,
  input  wire display_ram_pkg::host_cmd_t                      cmd_in,
  input  wire display_ram_pkg::access_mode_t                   access_mode,
  input  wire display_ram_pkg::step_cfg_t                      step_cfg,
  input  wire logic                                            pixel_polarity_invert,
  input  wire logic [display_ram_pkg::ROW_W-1:0]               start_line,
  input  wire logic                                            line_latch_pulse,
  input  wire logic                                            frame_start_marker,
  output var  logic                                            rd_valid,
  output var  logic [15:0]                                     rd_data,
  output var  logic [display_ram_pkg::COL_W-1:0]               col_pointer,
  output var  logic [display_ram_pkg::ROW_W-1:0]               row_pointer,
  output var  logic [display_ram_pkg::ROW_W-1:0]               line_address,
  output var  logic [display_ram_pkg::SEG_COUNT-1:0][display_ram_pkg::LEVEL_BITS-1:0] seg_level
);
  import display_ram_pkg::*;

  // ===================================================================
  // Elaboration checks
  // ===================================================================
  generate
    if (CMD_DEPTH < 2) begin : g_bad_depth
      $error("display_ram_addressing needs a command FIFO of at least 2");
    end
    if (SEG_COUNT != 3 * POS_COUNT) begin : g_bad_seg
      $error("three segments per memory position are expected");
    end
  endgenerate

  // ===================================================================
  // Decoding helpers
  // ===================================================================
  // Highest legal column for the selected bus width and colour mode
  function automatic logic [COL_W-1:0] col_limit(input access_mode_t m);
    logic pal;
    pal = m.palette_color_mode && !m.high_color_mode;
    if (m.bus_width_select) begin
      col_limit = pal ? COL_MAX_16_PAL : COL_MAX_16_WIDE;
    end else begin
      col_limit = pal ? COL_MAX_8_PAL : COL_MAX_8_WIDE;
    end
  endfunction : col_limit

  // Scales a 6-bit code onto 48 levels (0..47)
  function automatic logic [LEVEL_BITS-1:0] to_level(input logic [5:0] v);
    logic [7:0] prod;
    prod = {2'b00, v} + {1'b0, v, 1'b0};
    to_level = prod[7:2];
  endfunction : to_level

  // One pixel word into three segment levels, by colour mode
  function automatic logic [3*LEVEL_BITS-1:0] pixel_levels(
      input logic [15:0] w, input logic [7:0] b, input access_mode_t m);
    logic [5:0] r6;
    logic [5:0] g6;
    logic [5:0] b6;
    r6 = '0;
    g6 = '0;
    b6 = '0;
    if (m.palette_color_mode && !m.high_color_mode) begin
      r6 = {b[7:5], b[7:5]};
      g6 = {b[4:2], b[4:2]};
      b6 = {b[1:0], b[1:0], b[1:0]};
    end else if (m.high_color_mode) begin
      r6 = {w[15:11], w[15]};
      g6 = w[10:5];
      b6 = {w[4:0], w[4]};
    end else begin
      r6 = {w[11:8], w[11:10]};
      g6 = {w[7:4], w[7:6]};
      b6 = {w[3:0], w[3:2]};
    end
    pixel_levels = {to_level(b6), to_level(g6), to_level(r6)};
  endfunction : pixel_levels

  // ===================================================================
  // Command FIFO
  // ===================================================================
  typedef enum logic {ST_IDLE = 1'b0, ST_FETCH = 1'b1} engine_state_t;

  engine_state_t state_reg;
  host_cmd_t     head;
  logic          head_valid;
  logic          head_take;

  // Reads wait one cycle for the prefetch, which back-pressures the host
  assign head_take = head_valid && (state_reg == ST_IDLE);

  cmd_fifo #(
    .WIDTH ($bits(host_cmd_t)),
    .DEPTH (CMD_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd_in),
    .out_valid (head_valid),
    .out_ready (head_take),
    .out_data  (head)
  );

  // ===================================================================
  // Effective address
  // ===================================================================
  logic [COL_W-1:0] col_max;
  logic [COL_W-1:0] eff_col;
  logic [6:0]       eff_word;
  logic             eff_lane;

  always_comb begin
    col_max  = col_limit(access_mode);
    eff_col  = access_mode.segment_reverse ? (col_max - col_pointer)
                                           : col_pointer;
    eff_word = access_mode.bus_width_select ? eff_col[6:0] : eff_col[7:1];
    eff_lane = eff_col[0];
  end

  // ===================================================================
  // Pointer stepping
  // ===================================================================
  logic [COL_W-1:0] col_next;
  logic [ROW_W-1:0] row_next;
  logic [COL_W-1:0] win_col_start_reg;
  logic [ROW_W-1:0] win_row_start_reg;
  logic             access_step;

  assign access_step = head_take &&
                       (head.kind == CMD_WRITE || head.kind == CMD_READ);

  always_comb begin
    col_next = col_pointer;
    row_next = row_pointer;
    if (step_cfg.region_access_on) begin
      if (col_pointer == step_cfg.window_col_limit) begin
        col_next = win_col_start_reg;
        row_next = (row_pointer == step_cfg.window_row_limit) ?
                   win_row_start_reg : row_pointer + 1'b1;
      end else begin
        col_next = col_pointer + 1'b1;
      end
    end else if (step_cfg.col_auto_step) begin
      // Pointer always counts up; reversal is done in the address map
      if (col_pointer >= col_max) begin
        col_next = COL_RESET;
        if (step_cfg.row_auto_step) begin
          row_next = (row_pointer == ROW_MAX) ? ROW_RESET : row_pointer + 1'b1;
        end
      end else begin
        col_next = col_pointer + 1'b1;
      end
    end else if (step_cfg.row_auto_step) begin
      row_next = (row_pointer == ROW_MAX) ? ROW_RESET : row_pointer + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      col_pointer       <= COL_RESET;
      row_pointer       <= ROW_RESET;
      win_col_start_reg <= COL_RESET;
      win_row_start_reg <= ROW_RESET;
    end else if (head_take && head.kind == CMD_SET_COL) begin
      col_pointer       <= head.value[COL_W-1:0];
      win_col_start_reg <= head.value[COL_W-1:0];
    end else if (head_take && head.kind == CMD_SET_ROW) begin
      row_pointer       <= head.value[ROW_W-1:0];
      win_row_start_reg <= head.value[ROW_W-1:0];
    end else if (access_step) begin
      col_pointer <= col_next;
      row_pointer <= row_next;
    end
  end

  // ===================================================================
  // Host memory access and read prefetch
  // ===================================================================
  logic        host_we;
  logic        host_re;
  logic [1:0]  host_be;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic [15:0] read_hold_reg;
  logic        fetch_lane_reg;
  logic        fetch_wide_reg;

  assign host_we = head_take && head.kind == CMD_WRITE;
  assign host_re = head_take && head.kind == CMD_READ;

  always_comb begin
    if (access_mode.bus_width_select) begin
      host_be    = 2'b11;
      host_wdata = head.value;
    end else begin
      host_be    = eff_lane ? 2'b10 : 2'b01;
      host_wdata = {head.value[7:0], head.value[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE:  state_reg <= host_re ? ST_FETCH : ST_IDLE;
        ST_FETCH: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_lane_reg <= 1'b0;
      fetch_wide_reg <= 1'b0;
    end else if (host_re) begin
      fetch_lane_reg <= eff_lane;
      fetch_wide_reg <= access_mode.bus_width_select;
    end
  end

  // A read answers with the previous prefetch, so the first after a set is a dummy
  always_ff @(posedge clk) begin
    if (rst) begin
      read_hold_reg <= '0;
    end else if (state_reg == ST_FETCH) begin
      if (fetch_wide_reg) begin
        read_hold_reg <= host_rdata;
      end else begin
        read_hold_reg <= {8'h00, fetch_lane_reg ? host_rdata[15:8]
                                                : host_rdata[7:0]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= host_re;
      if (host_re) begin
        rd_data <= read_hold_reg;
      end
    end
  end

  // ===================================================================
  // Display memory
  // ===================================================================
  logic                 lp_prev_reg;
  logic                 lp_rise;
  logic                 lp_fall;
  logic [ROW_WIDTH-1:0] disp_latch;

  assign lp_rise = line_latch_pulse && !lp_prev_reg;
  assign lp_fall = !line_latch_pulse && lp_prev_reg;

  display_ram_array #(
    .ROWS  (ROW_COUNT),
    .WORDS (POS_COUNT),
    .WBITS (WORD_BITS)
  ) u_ram (
    .clk        (clk),
    .host_we    (host_we),
    .host_be    (host_be),
    .host_re    (host_re),
    .host_row   (row_pointer),
    .host_word  (eff_word),
    .host_wdata (host_wdata),
    .host_rdata (host_rdata),
    .disp_re    (lp_rise),
    .disp_row   (line_address),
    .disp_rdata (disp_latch)
  );

  // ===================================================================
  // Line counter and segment output
  // ===================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      lp_prev_reg <= 1'b0;
    end else begin
      lp_prev_reg <= line_latch_pulse;
    end
  end

  // Driven by LCD timing alone; host pointers never touch it
  always_ff @(posedge clk) begin
    if (rst) begin
      line_address <= ROW_RESET;
    end else if (frame_start_marker) begin
      line_address <= start_line;
    end else if (lp_fall) begin
      line_address <= line_address + 1'b1;
    end
  end

  logic [ROW_WIDTH-1:0] lit_bits;
  logic [SEG_COUNT-1:0][LEVEL_BITS-1:0] level_next;

  assign lit_bits = disp_latch ^ {ROW_WIDTH{pixel_polarity_invert}};

  generate
    for (genvar p = 0; p < POS_COUNT; p++) begin : g_pix
      // Palette pixels pack one per byte in the low half of the row
      assign {level_next[3*p+2], level_next[3*p+1], level_next[3*p]} =
        pixel_levels(lit_bits[p*WORD_BITS +: WORD_BITS],
                     lit_bits[p*8 +: 8], access_mode);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      seg_level <= '0;
    end else if (lp_fall) begin
      seg_level <= level_next;
    end
  end
endmodule : display_ram_addressing

`default_nettype wire

// >>> display_ram_pkg.sv
// Shared constants and carrier types for the display RAM addressing block.
// Assumes a single 20 MHz clock domain; all users import this package.
// Notes on behaviour
// - Memory is 128 positions of 16 bits across, 128 rows down.
// - Each segment gets a 48-level value from 6 bits; three segments per pixel.
// - Column pointer addresses across, row pointer down; column range follows mode.
// - With auto-step on, pointers advance after every memory read and write.
// - Rising line latch pulse copies one full row into the display latch.
// - Falling line latch pulse presents the latched row to the segments.
// - While the frame marker is high, line counter loads the start line.
// - Line counter advances on each falling edge of the line latch pulse while the frame marker is low.
// - Line counter follows LCD timing only, never the host pointers.
// - Window starts at the loaded pointers and ends at the limit values.
// - Polarity flag 0 lights bits at 1; flag 1 inverts that relation.
// - Segment-order flag mirrors host column access to reverse segment order.
// - Reversed order still increments the pointer; effective column moves down.
// - Effective row address is the row pointer unchanged.
// - Palette bit 1 with high-colour bit 0 selects 256-colour mapping.
// - Both bits 0 give 4096 colours; high-colour bit alone gives 65K.
// - Bus width bit 0 means 8-bit host data, 1 means 16-bit.
// - After a pointer set, the first read is a dummy; data comes second.
`default_nettype none

package display_ram_pkg;
  localparam int ROW_COUNT   = 128;
  localparam int POS_COUNT   = 128;
  localparam int WORD_BITS   = 16;
  localparam int ROW_WIDTH   = POS_COUNT * WORD_BITS;
  localparam int SEG_COUNT   = 384;
  localparam int LEVEL_BITS  = 6;
  localparam int FIFO_DEPTH  = 16;
  localparam int COL_W       = 8;
  localparam int ROW_W       = 7;

  localparam logic [7:0] COL_MAX_8_WIDE  = 8'hff;
  localparam logic [7:0] COL_MAX_8_PAL   = 8'h7f;
  localparam logic [7:0] COL_MAX_16_WIDE = 8'h7f;
  localparam logic [7:0] COL_MAX_16_PAL  = 8'h3f;
  localparam logic [6:0] ROW_MAX         = 7'h7f;
  localparam logic [6:0] ROW_RESET       = 7'h00;
  localparam logic [7:0] COL_RESET       = 8'h00;

  typedef enum logic [1:0] {
    CMD_WRITE   = 2'b00,
    CMD_READ    = 2'b01,
    CMD_SET_COL = 2'b10,
    CMD_SET_ROW = 2'b11
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t   kind;
    logic [15:0] value;
  } host_cmd_t;

  typedef struct packed {
    logic bus_width_select;
    logic palette_color_mode;
    logic high_color_mode;
    logic segment_reverse;
  } access_mode_t;

  typedef struct packed {
    logic       region_access_on;
    logic       col_auto_step;
    logic       row_auto_step;
    logic [7:0] window_col_limit;
    logic [6:0] window_row_limit;
  } step_cfg_t;
endpackage : display_ram_pkg

`default_nettype wire

// >>> display_ram_store.sv
// Display RAM array and the host command FIFO.
// Assumes one clock; reads return from a register one cycle after request.
`default_nettype none

// =====================================================================
// Row-wide memory: word port for the host, row port for the display
// =====================================================================
module display_ram_array #(
  parameter int ROWS  = 128,
  parameter int WORDS = 128,
  parameter int WBITS = 16
) (
  input  wire logic                            clk,
  input  wire logic                            host_we,
  input  wire logic [1:0]                      host_be,
  input  wire logic                            host_re,
  input  wire logic [$clog2(ROWS)-1:0]         host_row,
  input  wire logic [$clog2(WORDS)-1:0]        host_word,
  input  wire logic [WBITS-1:0]                host_wdata,
  output var  logic [WBITS-1:0]                host_rdata,
  input  wire logic                            disp_re,
  input  wire logic [$clog2(ROWS)-1:0]         disp_row,
  output var  logic [WORDS*WBITS-1:0]          disp_rdata
);
  localparam int HALF = WBITS / 2;
  logic [WORDS*WBITS-1:0] mem [ROWS];

  generate
    if (WBITS % 2 != 0) begin : g_bad
      $error("display_ram_array needs an even word width");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (host_we && host_be[0]) begin
      mem[host_row][host_word*WBITS +: HALF] <= host_wdata[HALF-1:0];
    end
    if (host_we && host_be[1]) begin
      mem[host_row][host_word*WBITS+HALF +: HALF] <= host_wdata[WBITS-1:HALF];
    end
  end

  always_ff @(posedge clk) begin
    if (host_re) begin
      host_rdata <= mem[host_row][host_word*WBITS +: WBITS];
    end
  end

  always_ff @(posedge clk) begin
    if (disp_re) begin
      disp_rdata <= mem[disp_row];
    end
  end
endmodule : display_ram_array

// =====================================================================
// Synchronous FIFO with honest full and empty
// =====================================================================
module cmd_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("cmd_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = store[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cmd_fifo

`default_nettype wire

// >>> display_ram_addressing_chk.sv
// Port checker for display_ram_addressing: reads, line counter, segments.
// Assumes bind to the top module; one clock, synchronous reset.
`default_nettype none
module display_ram_addressing_chk
  import display_ram_pkg::*;
(
  input wire logic                                  clk,
  input wire logic                                  rst,
  input wire logic                                  cmd_valid,
  input wire logic                                  cmd_ready,
  input wire display_ram_pkg::host_cmd_t            cmd_in,
  input wire logic [display_ram_pkg::ROW_W-1:0]     start_line,
  input wire logic                                  line_latch_pulse,
  input wire logic                                  frame_start_marker,
  input wire logic                                  rd_valid,
  input wire logic [15:0]                           rd_data,
  input wire logic [display_ram_pkg::COL_W-1:0]     col_pointer,
  input wire logic [display_ram_pkg::ROW_W-1:0]     row_pointer,
  input wire logic [display_ram_pkg::ROW_W-1:0]     line_address,
  input wire logic [display_ram_pkg::SEG_COUNT-1:0][display_ram_pkg::LEVEL_BITS-1:0] seg_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ===================================================================
  // Helper counters and assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Reads taken but not answered yet
  logic [5:0] pend;
  logic [5:0] idle;
  always_ff @(posedge clk) begin
    if (rst)
      pend <= 6'h00;
    else
      pend <= pend + 6'(cmd_valid && cmd_ready && cmd_in.kind == CMD_READ) - 6'(rd_valid);
  end
  always_ff @(posedge clk) begin
    if (rst || (cmd_valid && cmd_ready))
      idle <= 6'h00;
    else if (idle != 6'h3f)
      idle <= idle + 6'h01;
  end
  line_load_a: assert property (
    frame_start_marker |=> line_address == $past(start_line))
    else $error("line counter not loaded");
  line_step_a: assert property (
    $fell(line_latch_pulse) && !frame_start_marker
    |=> line_address == $past(line_address) + 7'h01)
    else $error("line counter did not step");
  line_hold_a: assert property (
    !frame_start_marker && !$fell(line_latch_pulse) |=> $stable(line_address))
    else $error("line counter moved without timing");
  seg_hold_a: assert property (
    !$fell(line_latch_pulse) |=> $stable(seg_level))
    else $error("segments changed outside latch fall");
  rd_pulse_a: assert property (
    rd_valid |=> !rd_valid)
    else $error("read answer longer than one cycle");
  rd_hold_a: assert property (
    !rd_valid |-> $stable(rd_data))
    else $error("read data changed without answer");
  rd_cause_a: assert property (
    rd_valid |-> pend != 6'h00)
    else $error("read answer without read");
  rd_due_a: assert property (
    pend != 6'h00 |-> ##[0:40] rd_valid)
    else $error("read answer overdue");
  ptr_idle_a: assert property (
    idle > 6'h28 |-> $stable(col_pointer) && $stable(row_pointer))
    else $error("pointer moved without access");
endmodule : display_ram_addressing_chk
`default_nettype wire

// >>> host_model.sv
// Host processor model: pushes commands and collects read answers.
// Assumes every call starts at a falling clock edge.
`default_nettype none
module host_model
  import display_ram_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       cmd_ready,
  input  wire logic                       rd_valid,
  input  wire logic [15:0]                rd_data,
  output var  logic                       cmd_valid,
  output var  display_ram_pkg::host_cmd_t cmd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ===================================================================
  // Command tasks; callers keep pointers in range and window ends
  // not below starts
  initial begin
    cmd_valid = 1'b0;
    cmd_in = '0;
  end
  task automatic push(cmd_kind_t k, logic [15:0] v);
    cmd_valid = 1'b1;
    cmd_in = '{k, v};
    while (!cmd_ready)
      @(negedge clk);
    @(negedge clk);
  endtask : push
  // Released lines show inverted data so stale values never match
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_in = ~cmd_in;
    @(negedge clk);
  endtask : idle
  task automatic rd(output logic [15:0] d);
    push(CMD_READ, 16'h0000);
    idle();
    for (int i = 0; i < 8 && !rd_valid; i++)
      @(negedge clk);
    d = rd_data;
  endtask : rd
endmodule : host_model
`default_nettype wire

// >>> tb.sv
// Testbench for display_ram_addressing with a byte-level memory model.
// Assumes host_model and the checker are compiled first.
`default_nettype none
module tb
  import display_ram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ===================================================================
  // Signals, model and tasks
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_ready, pol, lp, fm, rd_valid;
  host_cmd_t cmd_in;
  access_mode_t am;
  step_cfg_t sc;
  logic [ROW_W-1:0] sl, row_pointer, line_address;
  logic [COL_W-1:0] col_pointer;
  logic [15:0] rd_data, pf;
  logic [SEG_COUNT-1:0][LEVEL_BITS-1:0] seg_level;
  logic [7:0] mem[int];
  logic [31:0] seed = 32'h00000060;
  bit pfv, full_seen;
  int mismatches, checks_done, cycles, nrd, base, mc, mr, ws, rs;
  host_model host (.clk(clk), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_in(cmd_in));
  display_ram_addressing #(.CMD_DEPTH(16)) i_display_ram_addressing (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_in(cmd_in), .access_mode(am),
    .step_cfg(sc), .pixel_polarity_invert(pol), .start_line(sl), .line_latch_pulse(lp),
    .frame_start_marker(fm), .rd_valid(rd_valid), .rd_data(rd_data),
    .col_pointer(col_pointer), .row_pointer(row_pointer), .line_address(line_address),
    .seg_level(seg_level));
  always #25 clk = ~clk;
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : xs
  function automatic int cmax();
    if (am.bus_width_select)
      return am.palette_color_mode ? 8'h3f : 8'h7f;
    return am.palette_color_mode ? 8'h7f : 8'hff;
  endfunction : cmax
  function automatic int key();
    int e = am.segment_reverse ? cmax() - mc : mc;
    return mr * 256 + (am.bus_width_select ? 2 * e : e);
  endfunction : key
  function automatic void mstep();
    if (sc.region_access_on && mc == sc.window_col_limit) begin
      mc = ws;
      mr = (mr == sc.window_row_limit) ? rs : mr + 1;
    end else if (sc.col_auto_step)
      mc = (mc == cmax()) ? 0 : mc + 1;
  endfunction : mstep
  task automatic chk_pos(string n, logic [7:0] e, logic [7:0] g);
    chk_word(n, {8'h00, e}, {8'h00, g});
  endtask : chk_pos
  task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic op(cmd_kind_t k, logic [15:0] v);
    host.push(k, v);
    host.idle();
    pfv = 1'b0;
  endtask : op
  task automatic setc(logic [7:0] c);
    op(CMD_SET_COL, {8'h00, c});
    mc = c;
    ws = c;
  endtask : setc
  task automatic setr(logic [6:0] r);
    op(CMD_SET_ROW, {9'h000, r});
    mr = r;
    rs = r;
  endtask : setr
  task automatic mwr(logic [15:0] v);
    op(CMD_WRITE, v);
    mem[key()] = v[7:0];
    if (am.bus_width_select)
      mem[key() + 1] = v[15:8];
    mstep();
  endtask : mwr
  task automatic mrd();
    logic [15:0] d;
    host.rd(d);
    if (pfv)
      chk_word("rd_data", pf, d);
    pf = am.bus_width_select ? {mem[key() + 1], mem[key()]} : {8'h00, mem[key()]};
    pfv = 1'b1;
    mstep();
  endtask : mrd
  task automatic frame(logic [6:0] v);
    fm = 1'b1;
    sl = v;
    repeat (2) @(negedge clk);
    fm = 1'b0;
    @(negedge clk);
  endtask : frame
  task automatic pulse();
    lp = 1'b1;
    repeat (3) @(negedge clk);
    lp = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  always @(negedge clk) begin
    cycles++;
    if (rd_valid === 1'b1)
      nrd++;
    if (cmd_ready === 1'b0)
      full_seen = 1'b1;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    am = '{1'b1, 1'b0, 1'b1, 1'b0};
    sc = '{1'b0, 1'b1, 1'b0, 8'h00, 7'h00};
    {pol, lp, fm, sl} = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    setr(7'h09);
    setc(8'h7e);
    repeat (3) mwr(xs());
    chk_pos("col_pointer", 8'h01, col_pointer);
    setc(8'h7e);
    repeat (4) mrd();
    for (int m = 0; m < 3; m++) begin
      am = '{1'b0, m == 2, m == 1, 1'b0};
      setc(8'(cmax()));
      mwr(xs());
      chk_pos("col_pointer", 8'h00, col_pointer);
    end
    setc(8'h14);
    repeat (4) mwr(xs());
    setc(8'h14);
    repeat (3) mrd();
    am = '{1'b1, 1'b0, 1'b1, 1'b1};
    setc(8'h0a);
    repeat (2) mwr(xs());
    chk_pos("col_pointer", 8'h0c, col_pointer);
    am.segment_reverse = 1'b0;
    setc(8'h0a);
    repeat (3) mrd();
    setc(8'h74);
    repeat (3) mrd();
    $display("test modes done");
    sc = '{1'b1, 1'b1, 1'b1, 8'h04, 7'h15};
    setr(7'h14);
    setc(8'h03);
    repeat (5) mwr(xs());
    chk_pos("col_pointer", 8'h04, col_pointer);
    chk_pos("row_pointer", 8'h14, {1'b0, row_pointer});
    sc = '{1'b0, 1'b1, 1'b0, 8'h00, 7'h00};
    setr(7'h15);
    setc(8'h03);
    repeat (3) mrd();
    $display("test window done");
    setr(7'h28);
    setc(8'h00);
    mwr(16'h0000);
    frame(7'h27);
    chk_pos("line_address", 8'h27, {1'b0, line_address});
    pulse();
    chk_pos("line_address", 8'h28, {1'b0, line_address});
    pulse();
    chk_pos("seg_level", 8'h00, {2'b00, seg_level[1]});
    pol = 1'b1;
    frame(7'h28);
    pulse();
    chk_pos("seg_level", 8'h2f, {2'b00, seg_level[1]});
    $display("test lines done");
    base = nrd;
    for (int i = 0; i < 40; i++)
      host.push(CMD_READ, 16'h0000);
    host.idle();
    repeat (90) @(negedge clk);
    chk_pos("reads", 8'h28, 8'(nrd - base));
    chk_pos("ready_low", 8'h01, {7'h00, full_seen});
    $display("test fifo done");
    end_of_test();
  end
endmodule : tb
bind display_ram_addressing display_ram_addressing_chk chk (.clk(clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_in(cmd_in), .start_line(start_line),
  .line_latch_pulse(line_latch_pulse), .frame_start_marker(frame_start_marker),
  .rd_valid(rd_valid), .rd_data(rd_data), .col_pointer(col_pointer),
  .row_pointer(row_pointer), .line_address(line_address), .seg_level(seg_level));
`default_nettype wire
